// ### logic/qpd_top.sv
// Four channel low-side predriver: serial frame, parallel inputs, fault timers.
// Assumes serial clock stands still while chip select is high.
//
// Function
// - Shift serial input into LSB on rising clock
// - Under four clocks, fault bits reach outputs
// - Eight bits accepted; last four are commands
// - Chip select rise loads command register
// - Command 1 turns gate on, 0 off
// - Serial output advances on falling clock
// - Fault MSB out at frame start, three follow
// - Faults captured only at chip select fall
// - Chip select high: idle input, float output, re-arm
// - Latched short cleared by off-then-on command
// - Retry variant clears short once condition gone
// - Gate on is parallel OR serial request
// - Parallel inputs act without any frame
// - Parallel input low-then-high clears latched short
// - Off-to-on starts 60 us short mask
// - Drain high 8 us flags fault, latches off
// - Retry variant pulses gate while shorted
// - Fault word has one bit per channel
// - Open load checked when off after 60 us
// - Drain low after mask flags open load
// - Short deglitch time is 8 us
// - Retry pulse 68 us every 10 ms
// - Battery fault forces gates off while present and flags, flag releases on frame start
module qpd_top
   import qpd_pkg::*;
#(
   parameter int MASK_CYC = `QPD_MASK_US * `QPD_CLK_MHZ,
   parameter int PW_CYC   = `QPD_PW_US * `QPD_CLK_MHZ,
   parameter int PER_CYC  = `QPD_PER_MS * `QPD_US_PER_MS * `QPD_CLK_MHZ
) (
   // Core clock and reset
   input  logic     clk,
   input  logic     rstn,
   // Serial link
   input  logic     serial_clk,
   input  logic     chip_sel_n,
   input  logic     serial_in,
   output logic     serial_out_data,
   output logic     serial_out_oe_n,
   // Parallel control and drain sensing
   input  qpd_nib_t parallel_on_inputs,
   input  qpd_nib_t drain_sense_inputs,
   input  logic     bat_over_volt,
   input  logic     bat_under_volt,
   input  logic     retry_mode,
   output qpd_nib_t gate_outputs,
   // Open-drain fault flag
   input  logic     fault_flag_n_level,
   output logic     fault_flag_n_drive,
   output logic     fault_flag_n_oe_n
);

   // Timer loads, all in core clock cycles
   localparam int       DGL_CYC = `QPD_DGL_US * `QPD_CLK_MHZ;
   localparam qpd_cnt_t MASK_C  = qpd_cnt_t'(MASK_CYC);
   localparam qpd_cnt_t DGL_C   = qpd_cnt_t'(DGL_CYC);
   localparam qpd_cnt_t PW_C    = qpd_cnt_t'(PW_CYC);
   localparam qpd_cnt_t PER_C   = qpd_cnt_t'(PER_CYC);

   // ------------------------------------------------------------------
   // Serial clock domain, rising edge: input shift and edge count
   // ------------------------------------------------------------------
   qpd_link_t link_q;
   qpd_link_t link_d;

   always_comb begin
      link_d = link_q;
      if (!chip_sel_n) begin
         link_d.bits  = {link_q.bits[`QPD_NCH-2:0], serial_in};
         link_d.edges = link_q.edges + `QPD_CNT_ONE;
      end
   end

   always_ff @(posedge serial_clk or negedge rstn) begin
      if (!rstn) begin
         link_q <= '0;
      end else begin
         link_q <= link_d;
      end
   end

   // ------------------------------------------------------------------
   // Serial clock domain, falling edge: output sequencing
   // ------------------------------------------------------------------
   logic       frame_rst_n;
   logic [2:0] nfall_q;
   logic [2:0] nfall_d;
   logic       out_q;
   logic       out_d;
   qpd_nib_t   snap_q;
   qpd_nib_t   snap_d;

   // Deselect resets the sequencer, so each frame starts at the top bit
   // frame side cleared while deselected
   assign frame_rst_n = rstn & ~chip_sel_n;

   always_comb begin
      nfall_d = nfall_q;
      if (nfall_q != `QPD_MIN_BITS) begin
         nfall_d = nfall_q + 3'h1;
      end
      if (nfall_d < `QPD_MIN_BITS) begin
         out_d = snap_q[2'(3'h3 - nfall_d)];
      end else begin
         out_d = link_q.bits[`QPD_TOP_BIT];
      end
   end

   // Falling-edge flops hand each bit out half a link cycle before its sample
   always_ff @(negedge serial_clk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         nfall_q <= 3'h0;
         out_q   <= 1'b0;
      end else begin
         nfall_q <= nfall_d;
         out_q   <= out_d;
      end
   end

   // Top fault bit must show before any link edge, hence the mux
   // MSB shown before first falling edge
   assign serial_out_data = (nfall_q == 3'h0) ? snap_q[`QPD_TOP_BIT] : out_q;

   // ------------------------------------------------------------------
   // Core domain: pin synchronisers
   // ------------------------------------------------------------------
   localparam int SW = 3 + 2 * `QPD_NCH;
   // Idle pin levels: deselected, no battery fault, drains high (no false open load)
   localparam logic [SW-1:0] S_IDLE = {1'b1, 1'b0, 1'b0, `QPD_NIB_ZERO, `QPD_NIB_ONES};
   logic [SW-1:0] s1_q;
   logic [SW-1:0] s2_q;
   logic [SW-1:0] s_raw;
   logic          cs_s;
   logic          bat_s;
   logic          retry_s;
   qpd_nib_t      par_s;
   qpd_nib_t      drain_s;
   logic          cs_prev_q;
   logic          cs_rise;
   logic          cs_fall;

   assign s_raw = {chip_sel_n, bat_over_volt | bat_under_volt, retry_mode,
                   parallel_on_inputs, drain_sense_inputs};

   // Two stages per pin; only the second stage is read
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q      <= S_IDLE;
         s2_q      <= S_IDLE;
         cs_prev_q <= 1'b1;
      end else begin
         s1_q      <= s_raw;
         s2_q      <= s1_q;
         cs_prev_q <= cs_s;
      end
   end

   assign cs_s    = s2_q[SW-1];
   assign bat_s   = s2_q[SW-2];
   assign retry_s = s2_q[SW-3];
   assign par_s   = s2_q[2*`QPD_NCH-1:`QPD_NCH];
   assign drain_s = s2_q[`QPD_NCH-1:0];
   // Edge history resets deselected, so release gives no false edge
   assign cs_rise = cs_s & ~cs_prev_q;
   assign cs_fall = ~cs_s & cs_prev_q;

   // ------------------------------------------------------------------
   // Core domain: frame end, command register, fault snapshot
   // ------------------------------------------------------------------
   qpd_nib_t   cmd_q;
   qpd_nib_t   cmd_d;
   qpd_nib_t   cmd_new;
   logic [3:0] base_q;
   logic [3:0] base_d;
   logic [3:0] nbits;
   logic [2:0] nsh;
   qpd_nib_t   fault_flag_n;
   logic       bat_flag_q;
   logic       bat_flag_d;
   logic       oe_n_q;
   logic       flag_oe_n_q;
   logic       flag_oe_n_d;

   // Link words are steady here: serial clock idles after chip select rise
   assign nbits = link_q.edges - base_q;
   // fewer than four clocks leaves fault bits in place
   assign nsh = (nbits >= 4'(`QPD_MIN_BITS)) ? `QPD_MIN_BITS : nbits[2:0];

   // Short frames leave unshifted fault bits in the upper channels
   for (genvar b = 0; b < `QPD_NCH; b++) begin : g_cmd
      logic [2:0] src;
      assign src = 3'(b) - nsh;
      // last four shifted in are commands
      assign cmd_new[b] = (3'(b) < nsh) ? link_q.bits[b] : snap_q[src[1:0]];
   end

   always_comb begin
      cmd_d      = cmd_q;
      base_d     = base_q;
      snap_d     = snap_q;
      bat_flag_d = bat_flag_q;
      if (cs_rise) begin
         cmd_d  = cmd_new;
         base_d = link_q.edges;
      end
      // snapshot frozen once chip select is low
      if (cs_s) begin
         snap_d = fault_flag_n;
      end
      // battery flag releases at frame start
      if (cs_fall) begin
         bat_flag_d = 1'b0;
      end
      if (bat_s) begin
         bat_flag_d = 1'b1;
      end
      flag_oe_n_d = ~(|fault_flag_n | bat_flag_d);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_q       <= `QPD_NIB_ZERO;
         base_q      <= 4'h0;
         snap_q      <= `QPD_NIB_ZERO;
         bat_flag_q  <= 1'b0;
         oe_n_q      <= 1'b1;
         flag_oe_n_q <= 1'b1;
      end else begin
         cmd_q       <= cmd_d;
         base_q      <= base_d;
         snap_q      <= snap_d;
         bat_flag_q  <= bat_flag_d;
         // Enable trails the pin by the synchroniser delay
         // output floats while deselected
         oe_n_q      <= cs_s;
         flag_oe_n_q <= flag_oe_n_d;
      end
   end

   assign serial_out_oe_n    = oe_n_q;
   assign fault_flag_n_oe_n  = flag_oe_n_q;
   // Open drain: only ever pulls low, the enable carries the fault
   assign fault_flag_n_drive = 1'b0;

   // ------------------------------------------------------------------
   // Core domain: per-channel gate, timers and faults
   // ------------------------------------------------------------------
   qpd_nib_t gate_q;
   qpd_nib_t req_q;
   qpd_nib_t short_q;
   qpd_nib_t open_q;
   qpd_cnt_t mask_q [`QPD_NCH];
   qpd_cnt_t dgl_q  [`QPD_NCH];
   qpd_cnt_t per_q  [`QPD_NCH];

   assign fault_flag_n = short_q | open_q;

   // One copy of gate, timers and fault state per channel
   for (genvar i = 0; i < `QPD_NCH; i++) begin : g_ch
      logic     req;
      logic     pulse;
      logic     chk;
      logic     gate_d;
      logic     short_d;
      logic     open_d;
      qpd_cnt_t mask_d;
      qpd_cnt_t dgl_d;
      qpd_cnt_t per_d;

      always_comb begin
         req   = par_s[i] | cmd_q[i];
         pulse = per_q[i] < PW_C;
         // low-duty pulse train while shorted in retry mode
         gate_d = req & ~bat_s & (~short_q[i] | (retry_s & pulse));
         // mask restarts on each gate change
         if (gate_d != gate_q[i]) begin
            mask_d = MASK_C;
         end else if (mask_q[i] != '0) begin
            mask_d = mask_q[i] - qpd_cnt_t'(1);
         end else begin
            mask_d = '0;
         end
         // Battery fault blanks load checks until it is gone
         // checks run on counted core cycles
         chk = ~bat_s & (mask_q[i] == '0) & (gate_d == gate_q[i]);

         // Counter parks at the pulse width, so a new short starts in the off phase
         // retry period and pulse width
         per_d = '0;
         if (short_q[i] && retry_s) begin
            per_d = (per_q[i] >= PER_C - qpd_cnt_t'(1)) ? '0
                                                         : per_q[i] + qpd_cnt_t'(1);
         end else if (!short_q[i]) begin
            per_d = PW_C;
         end

         short_d = short_q[i];
         if (short_q[i]) begin
            if (retry_s) begin
               // short gone during a pulse clears it
               if (!req || (gate_q[i] && chk && !drain_s[i])) begin
                  short_d = 1'b0;
               end
            end else if (req && !req_q[i]) begin
               short_d = 1'b0;
            end
         end

         // Deglitch count holds at its limit while the drain stays high
         // drain high for deglitch time
         dgl_d = '0;
         if (gate_q[i] && chk && drain_s[i]) begin
            dgl_d = (dgl_q[i] == DGL_C) ? DGL_C : dgl_q[i] + qpd_cnt_t'(1);
         end
         if (dgl_d == DGL_C) begin
            short_d = 1'b1;
         end

         // Detection follows the clear, so a standing open load is seen again
         // open flag re-armed at frame end
         open_d = open_q[i] & ~cs_rise;
         if (!gate_q[i] && chk && !drain_s[i]) begin
            open_d = 1'b1;
         end
      end

      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            gate_q[i]  <= 1'b0;
            req_q[i]   <= 1'b0;
            short_q[i] <= 1'b0;
            open_q[i]  <= 1'b0;
            mask_q[i]  <= '0;
            dgl_q[i]   <= '0;
            per_q[i]   <= '0;
         end else begin
            gate_q[i]  <= gate_d;
            req_q[i]   <= req;
            short_q[i] <= short_d;
            open_q[i]  <= open_d;
            mask_q[i]  <= mask_d;
            dgl_q[i]   <= dgl_d;
            per_q[i]   <= per_d;
         end
      end
   end

   assign gate_outputs = gate_q;

endmodule : qpd_top

// ### logic/qpd_consts.svh
// Constants for the quad predriver serial and fault control block.
// Assumes a 100 MHz core clock; times are kept in their printed units.
`ifndef QPD_CONSTS_SVH
`define QPD_CONSTS_SVH

`define QPD_NCH       4
`define QPD_CLK_MHZ   100
`define QPD_MASK_US   60
`define QPD_DGL_US    8
`define QPD_PW_US     68
`define QPD_PER_MS    10
`define QPD_US_PER_MS 1000
`define QPD_TW        20
`define QPD_NIB_ZERO  4'h0
`define QPD_NIB_ONES  4'hF
`define QPD_MIN_BITS  3'h4
`define QPD_TOP_BIT   2'h3
`define QPD_CNT_ONE   4'h1

`endif

// ### logic/qpd_pkg.sv
// Types shared by the quad predriver control block.
// Assumes qpd_consts.svh is on the include path.
`include "qpd_consts.svh"

package qpd_pkg;
   typedef logic [`QPD_NCH-1:0] qpd_nib_t;
   typedef logic [`QPD_TW-1:0]  qpd_cnt_t;

   // Serial input history and free-running rising edge count
   typedef struct packed {
      qpd_nib_t   bits;
      logic [3:0] edges;
   } qpd_link_t;
endpackage : qpd_pkg

// ### test/qpd_top_properties.sv
// Concurrent checks on the predriver top ports, bound into qpd_top.
// Assumes link pins are seen as asynchronous levels in the core clock domain.
module qpd_top_props
   import qpd_pkg::*;
#(
   parameter int MASK_CYC = 6000
) (
   // Core
   input logic     clk,
   input logic     rstn,
   // Link
   input logic     chip_sel_n,
   input logic     serial_out_oe_n,
   // Channels
   input qpd_nib_t parallel_on_inputs,
   input qpd_nib_t drain_sense_inputs,
   input logic     bat_over_volt,
   input logic     bat_under_volt,
   input logic     retry_mode,
   input qpd_nib_t gate_outputs,
   // Fault flag
   input logic     fault_flag_n_drive,
   input logic     fault_flag_n_oe_n
);
   localparam int SLIM = MASK_CYC + 810;
   localparam int OLIM = MASK_CYC + 6;
   localparam int SEARLY = MASK_CYC + 790;
   logic        bat;
   logic        shrt;
   logic        opn;
   logic [15:0] scnt_q, scnt_d;
   logic [15:0] ocnt_q, ocnt_d;

   assign bat  = bat_over_volt | bat_under_volt;
   assign shrt = gate_outputs[0] & drain_sense_inputs[0] & ~retry_mode & ~bat;
   assign opn  = ~gate_outputs[0] & ~drain_sense_inputs[0] & ~bat;

   // Channel 0 cycles spent shorted while on, and open while off
   always_comb begin
      scnt_d = shrt ? scnt_q + {15'h0000, ~&scnt_q} : 16'h0000;
      ocnt_d = opn ? ocnt_q + {15'h0000, ~&ocnt_q} : 16'h0000;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scnt_q <= 16'h0000;
         ocnt_q <= 16'h0000;
      end else begin
         scnt_q <= scnt_d;
         ocnt_q <= ocnt_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_par_up;
      $rose(parallel_on_inputs[0]) ##1 (parallel_on_inputs[0] && !bat) [*6];
   endsequence

   a_flag_drive: assert property (fault_flag_n_drive == 1'b0)
      else $error("fault flag drive not low");
   a_bat_gates: assert property (bat [*5] |-> gate_outputs == 4'h0)
      else $error("gates on during battery fault");
   a_bat_flag: assert property (bat [*5] |-> !fault_flag_n_oe_n)
      else $error("flag idle during battery fault");
   a_oe_frame: assert property ($fell(chip_sel_n) |-> ##[1:4] !serial_out_oe_n)
      else $error("serial output not driven in frame");
   a_oe_release: assert property ($rose(chip_sel_n) |-> ##[1:4] serial_out_oe_n)
      else $error("serial output not released");
   a_oe_idle: assert property (chip_sel_n [*5] |-> serial_out_oe_n)
      else $error("serial output driven while idle");
   a_par_on: assert property (s_par_up |-> gate_outputs[0])
      else $error("parallel request did not turn gate on");
   a_short_early: assert property (scnt_q == SEARLY |-> gate_outputs[0])
      else $error("gate cut before mask and deglitch");
   a_short_cut: assert property (scnt_q <= SLIM)
      else $error("shorted gate not cut");
   a_open_flag: assert property (ocnt_q > OLIM |-> !fault_flag_n_oe_n)
      else $error("open load not flagged");
endmodule : qpd_top_props

bind qpd_top qpd_top_props #(.MASK_CYC(MASK_CYC)) u_props (
   .clk                (clk),
   .rstn               (rstn),
   .chip_sel_n         (chip_sel_n),
   .serial_out_oe_n    (serial_out_oe_n),
   .parallel_on_inputs (parallel_on_inputs),
   .drain_sense_inputs (drain_sense_inputs),
   .bat_over_volt      (bat_over_volt),
   .bat_under_volt     (bat_under_volt),
   .retry_mode         (retry_mode),
   .gate_outputs       (gate_outputs),
   .fault_flag_n_drive (fault_flag_n_drive),
   .fault_flag_n_oe_n  (fault_flag_n_oe_n)
);

// ### test/qpd_host.sv
// Host model: drives chip select, serial clock and data for one frame.
// Assumes 30 ns link clock that stands still outside frames.
module qpd_host (
   // Serial link
   output logic serial_clk,
   output logic chip_sel_n,
   output logic serial_in,
   input  logic serial_out_data
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      serial_clk = 1'b0;
      chip_sel_n = 1'b1;
      serial_in  = 1'b0;
   end

   // n clocks, select high after last bit
   task automatic frame(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      // Offset keeps link edges clear of core clock edges
      #3;
      chip_sel_n = 1'b0;
      #30;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in = tx[i];
         #15;
         rx = {rx[6:0], serial_out_data};
         serial_clk = 1'b1;
         #15;
         serial_clk = 1'b0;
      end
      #15;
      chip_sel_n = 1'b1;
      serial_in = ~serial_in;
      #100;
   endtask : frame
endmodule : qpd_host

// ### test/qpd_top_tb.sv
// Self-checking bench for the predriver top: frames, parallel inputs, faults.
// Assumes the host model drives the link; core inputs change on falling clk.
module qpd_top_tb
   import qpd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int MASK = 20;
   logic       clk, rstn, serial_clk, chip_sel_n, serial_in, serial_out_data;
   logic       serial_out_oe_n, bat_over_volt, bat_under_volt, retry_mode;
   logic       fault_flag_n_level, fault_flag_n_drive, fault_flag_n_oe_n;
   logic       sdo_line;
   qpd_nib_t   parallel_on_inputs, drain_sense_inputs, gate_outputs;
   logic [7:0] rx;
   int         mismatches, total_checks, cyc;

   // Open-drain flag wire with pull-up
   assign fault_flag_n_level = fault_flag_n_oe_n ? 1'b1 : fault_flag_n_drive;

   // Released data line shows the inverse of the last value
   assign sdo_line = serial_out_oe_n ? ~serial_out_data : serial_out_data;

   qpd_top #(.MASK_CYC(MASK), .PW_CYC(40), .PER_CYC(200)) uut (
      .clk                (clk),
      .rstn               (rstn),
      .serial_clk         (serial_clk),
      .chip_sel_n         (chip_sel_n),
      .serial_in          (serial_in),
      .serial_out_data    (serial_out_data),
      .serial_out_oe_n    (serial_out_oe_n),
      .parallel_on_inputs (parallel_on_inputs),
      .drain_sense_inputs (drain_sense_inputs),
      .bat_over_volt      (bat_over_volt),
      .bat_under_volt     (bat_under_volt),
      .retry_mode         (retry_mode),
      .gate_outputs       (gate_outputs),
      .fault_flag_n_level (fault_flag_n_level),
      .fault_flag_n_drive (fault_flag_n_drive),
      .fault_flag_n_oe_n  (fault_flag_n_oe_n)
   );
   qpd_host host (
      .serial_clk      (serial_clk),
      .chip_sel_n      (chip_sel_n),
      .serial_in       (serial_in),
      .serial_out_data (sdo_line)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic waitc(input int n);
      repeat (n) @(negedge clk);
   endtask : waitc

   task automatic xfer(input logic [7:0] tx, input int n);
      host.frame(tx, n, rx);
      @(negedge clk);
   endtask : xfer

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   // Drains follow the inverse of the command so no fault arises by accident
   initial begin
      rstn = 1'b0;
      parallel_on_inputs = 4'h0;
      drain_sense_inputs = 4'hF;
      bat_over_volt = 1'b0;
      bat_under_volt = 1'b0;
      retry_mode = 1'b0;
      waitc(16);
      rstn = 1'b1;
      waitc(4);
      check("gates", 8'(gate_outputs), 8'h00);
      check("oe_n", 8'(serial_out_oe_n), 8'h01);
      check("flag", 8'(fault_flag_n_level), 8'h01);
      xfer(8'h05, 4);
      drain_sense_inputs = 4'hA;
      waitc(6);
      check("word", rx, 8'h00);
      check("gates", 8'(gate_outputs), 8'h05);
      drain_sense_inputs = 4'h8;
      parallel_on_inputs = 4'h2;
      waitc(6);
      check("gates or", 8'(gate_outputs), 8'h07);
      parallel_on_inputs = 4'h0;
      drain_sense_inputs = 4'hA;
      xfer(8'h3C, 8);
      drain_sense_inputs = 4'h3;
      waitc(6);
      check("word8", rx, 8'h03);
      check("gates8", 8'(gate_outputs), 8'h0C);
      xfer(8'h01, 2);
      drain_sense_inputs = 4'hE;
      waitc(6);
      check("gates2", 8'(gate_outputs), 8'h01);
      xfer(8'h00, 4);
      waitc(MASK + 10);
      check("flag open", 8'(fault_flag_n_level), 8'h00);
      xfer(8'h00, 4);
      check("word open", rx, 8'h01);
      drain_sense_inputs = 4'hF;
      xfer(8'h00, 4);
      xfer(8'h00, 4);
      check("word clr", rx, 8'h00);
      check("flag clr", 8'(fault_flag_n_level), 8'h01);
      parallel_on_inputs = 4'h1;
      waitc(MASK + 830);
      check("gate short", 8'(gate_outputs), 8'h00);
      check("flag short", 8'(fault_flag_n_level), 8'h00);
      xfer(8'h00, 4);
      check("word short", rx, 8'h01);
      parallel_on_inputs = 4'h0;
      waitc(5);
      parallel_on_inputs = 4'h1;
      waitc(6);
      drain_sense_inputs = 4'hE;
      waitc(4);
      check("gate reen", 8'(gate_outputs), 8'h01);
      check("flag reen", 8'(fault_flag_n_level), 8'h01);
      bat_over_volt = 1'b1;
      waitc(8);
      check("flag bat", 8'(fault_flag_n_level), 8'h00);
      bat_over_volt = 1'b0;
      waitc(8);
      check("flag held", 8'(fault_flag_n_level), 8'h00);
      xfer(8'h00, 4);
      check("word bat", rx, 8'h00);
      check("flag rel", 8'(fault_flag_n_level), 8'h01);
      retry_mode = 1'b1;
      drain_sense_inputs = 4'hF;
      waitc(MASK + 830);
      check("gate retry off", 8'(gate_outputs), 8'h00);
      check("flag retry", 8'(fault_flag_n_level), 8'h00);
      waitc(140);
      check("gate pulse", 8'(gate_outputs), 8'h01);
      drain_sense_inputs = 4'hE;
      waitc(20);
      check("gate retry clr", 8'(gate_outputs), 8'h01);
      check("flag retry clr", 8'(fault_flag_n_level), 8'h01);
      finish_test();
   end
endmodule : qpd_top_tb
